/* File: inc/pipe_defs.vh */
`ifndef PIPE_DEFS_VH
`define PIPE_DEFS_VH

// instruction fields
`define F_OP        31:26
`define F_RS        25:21
`define F_RT        20:16
`define F_RD        15:11
`define F_FN        5:0
`define F_IMM       15:0
`define IMM_SIGN    15
`define IMM_EXT     16
`define WORD_SHIFT  2

// opcodes
`define OP_ALU      6'h00
`define OP_ADDI     6'h01
`define OP_LOAD     6'h02
`define OP_STORE    6'h03
`define OP_BEQ      6'h04
`define OP_BNE      6'h05
`define OP_BLTZ     6'h06
`define OP_BGEZ     6'h07

// function codes of register-register operations
`define FN_ADD      6'h00
`define FN_SUB      6'h01
`define FN_AND      6'h02
`define FN_OR       6'h03

// register file and addressing
`define GPR_COUNT   32
`define GPR_ZERO    5'h00
`define WORD_ZERO   32'h00000000
`define RESET_PC    32'h00000000
`define PC_STEP     32'h00000004
`define NOP_WORD    32'h00000000
`define SIGN_BIT    31

`endif

/* File: src/pipe_core.v */
// Overview of operation
// - five stages (fetch, decode, execute, memory, writeback) take one new instruction per cycle.
// - thirty-two general registers hold the integer operands, register zero reading as zero.
// - the shared address and data bus has two phases in every processor cycle; the data phase transfers only for a load or store.
// - the first half-cycle serves the instruction cache and the second the data cache.
// - each branch has one delay slot, filled by the instruction right after it.
// - a private adder forms the branch target in decode, beside the decoder.
// - a private comparator settles equal, not-equal and sign-against-zero tests in decode.
// - a load forms its address in execute and ends its data-cache access in memory stage.
// - a store uses one data-phase transfer and never holds the pipeline.
// - the delay-slot instruction always executes, branch taken or not.
`timescale 1ns/1ps
`include "pipe_defs.vh"
`default_nettype none

module pipe_core (
    // clock, reset, enable
    input  wire        i_clk_sys,
    input  wire        i_rst,
    input  wire        i_ce,
    // cache bus, two phases per processor cycle
    output reg  [31:0] o_bus_addr,
    output reg         o_bus_data_phase,
    output reg         o_bus_rd,
    output reg         o_bus_wr,
    output reg  [31:0] o_bus_wdata,
    input  wire [31:0] i_bus_rdata,
    // register writeback view
    output reg         o_wb_en,
    output reg  [4:0]  o_wb_reg,
    output reg  [31:0] o_wb_data
);

    localparam [1:0] ST_INSN = 2'b01;
    localparam [1:0] ST_DATA = 2'b10;

    function [31:0] sext;
        input [15:0] imm;
        begin
            sext = {{`IMM_EXT{imm[`IMM_SIGN]}}, imm};
        end
    endfunction

    // newest producer wins; a load still in memory stage is never offered
    function [31:0] fwd;
        input [4:0]  idx;
        input        a_en;
        input [4:0]  a_reg;
        input [31:0] a_val;
        input        b_en;
        input [4:0]  b_reg;
        input [31:0] b_val;
        input [31:0] base;
        begin
            if (idx == `GPR_ZERO)
                fwd = `WORD_ZERO;
            else if (a_en && a_reg == idx)
                fwd = a_val;
            else if (b_en && b_reg == idx)
                fwd = b_val;
            else
                fwd = base;
        end
    endfunction

    reg [1:0]  state_reg;
    reg [31:0] pc_reg;
    reg [31:0] fetch_ir_reg;
    reg [31:0] gpr [0:`GPR_COUNT-1];

    reg [31:0] if_id_ir;
    reg [31:0] if_id_pc;

    reg        id_ex_wen;
    reg [4:0]  id_ex_dest;
    reg        id_ex_load;
    reg        id_ex_store;
    reg        id_ex_use_imm;
    reg [5:0]  id_ex_fn;
    reg [4:0]  id_ex_rs;
    reg [4:0]  id_ex_rt;
    reg [31:0] id_ex_a;
    reg [31:0] id_ex_b;
    reg [31:0] id_ex_imm;

    reg        ex_mem_wen;
    reg [4:0]  ex_mem_dest;
    reg        ex_mem_load;
    reg        ex_mem_store;
    reg [31:0] ex_mem_res;
    reg [31:0] ex_mem_sdata;

    reg        mem_wb_wen;
    reg [4:0]  mem_wb_dest;
    reg [31:0] mem_wb_val;

    // decode stage
    wire [5:0]  id_op  = if_id_ir[`F_OP];
    wire [4:0]  id_rs  = if_id_ir[`F_RS];
    wire [4:0]  id_rt  = if_id_ir[`F_RT];
    wire [31:0] id_imm = sext(if_id_ir[`F_IMM]);
    wire        ex_fwd_en = ex_mem_wen & ~ex_mem_load;
    wire [31:0] id_a = fwd(id_rs, ex_fwd_en, ex_mem_dest, ex_mem_res,
                           mem_wb_wen, mem_wb_dest, mem_wb_val, gpr[id_rs]);
    wire [31:0] id_b = fwd(id_rt, ex_fwd_en, ex_mem_dest, ex_mem_res,
                           mem_wb_wen, mem_wb_dest, mem_wb_val, gpr[id_rt]);
    wire        id_alu = (id_op == `OP_ALU);
    wire        id_wen = id_alu | (id_op == `OP_ADDI) | (id_op == `OP_LOAD);
    wire [4:0]  id_dest = id_alu ? if_id_ir[`F_RD] : id_rt;

    wire [31:0] br_target = if_id_pc + `PC_STEP + (id_imm << `WORD_SHIFT);

    reg br_taken;
    always @* begin
        case (id_op)
            `OP_BEQ:  br_taken = (id_a == id_b);
            `OP_BNE:  br_taken = (id_a != id_b);
            `OP_BLTZ: br_taken = id_a[`SIGN_BIT];
            `OP_BGEZ: br_taken = ~id_a[`SIGN_BIT];
            default:  br_taken = 1'b0;
        endcase
    end

    wire [31:0] pc_next = br_taken ? br_target : pc_reg + `PC_STEP;

    // execute stage
    // no load interlock
    wire [31:0] ex_a = fwd(id_ex_rs, ex_fwd_en, ex_mem_dest, ex_mem_res,
                           mem_wb_wen, mem_wb_dest, mem_wb_val, id_ex_a);
    wire [31:0] ex_b = fwd(id_ex_rt, ex_fwd_en, ex_mem_dest, ex_mem_res,
                           mem_wb_wen, mem_wb_dest, mem_wb_val, id_ex_b);
    wire [31:0] ex_opnd = id_ex_use_imm ? id_ex_imm : ex_b;
    reg  [31:0] ex_res;
    always @* begin
        case (id_ex_fn)
            `FN_SUB: ex_res = ex_a - ex_opnd;
            `FN_AND: ex_res = ex_a & ex_opnd;
            `FN_OR:  ex_res = ex_a | ex_opnd;
            default: ex_res = ex_a + ex_opnd;
        endcase
    end

    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_reg        <= ST_INSN;
            pc_reg           <= `RESET_PC;
            fetch_ir_reg     <= `NOP_WORD;
            if_id_ir         <= `NOP_WORD;
            if_id_pc         <= `RESET_PC;
            id_ex_wen        <= 1'b0;
            id_ex_dest       <= `GPR_ZERO;
            id_ex_load       <= 1'b0;
            id_ex_store      <= 1'b0;
            id_ex_use_imm    <= 1'b0;
            id_ex_fn         <= `FN_ADD;
            id_ex_rs         <= `GPR_ZERO;
            id_ex_rt         <= `GPR_ZERO;
            id_ex_a          <= `WORD_ZERO;
            id_ex_b          <= `WORD_ZERO;
            id_ex_imm        <= `WORD_ZERO;
            ex_mem_wen       <= 1'b0;
            ex_mem_dest      <= `GPR_ZERO;
            ex_mem_load      <= 1'b0;
            ex_mem_store     <= 1'b0;
            ex_mem_res       <= `WORD_ZERO;
            ex_mem_sdata     <= `WORD_ZERO;
            mem_wb_wen       <= 1'b0;
            mem_wb_dest      <= `GPR_ZERO;
            mem_wb_val       <= `WORD_ZERO;
            o_bus_addr       <= `RESET_PC;
            o_bus_data_phase <= 1'b0;
            o_bus_rd         <= 1'b1;
            o_bus_wr         <= 1'b0;
            o_bus_wdata      <= `WORD_ZERO;
            o_wb_en          <= 1'b0;
            o_wb_reg         <= `GPR_ZERO;
            o_wb_data        <= `WORD_ZERO;
        end else if (i_ce) begin
            case (state_reg)
                ST_INSN: begin
                    fetch_ir_reg     <= i_bus_rdata;
                    state_reg        <= ST_DATA;
                    o_bus_addr       <= ex_mem_res;
                    o_bus_data_phase <= 1'b1;
                    o_bus_rd         <= ex_mem_load;
                    o_bus_wr         <= ex_mem_store;
                    o_bus_wdata      <= ex_mem_sdata;
                end
                ST_DATA: begin
                    state_reg        <= ST_INSN;
                    pc_reg           <= pc_next;
                    if_id_ir         <= fetch_ir_reg;
                    if_id_pc         <= pc_reg;
                    id_ex_wen        <= id_wen;
                    id_ex_dest       <= id_dest;
                    id_ex_load       <= (id_op == `OP_LOAD);
                    id_ex_store      <= (id_op == `OP_STORE);
                    id_ex_use_imm    <= ~id_alu;
                    id_ex_fn         <= id_alu ? if_id_ir[`F_FN] : `FN_ADD;
                    id_ex_rs         <= id_rs;
                    id_ex_rt         <= id_rt;
                    id_ex_a          <= id_a;
                    id_ex_b          <= id_b;
                    id_ex_imm        <= id_imm;
                    ex_mem_wen       <= id_ex_wen;
                    ex_mem_dest      <= id_ex_dest;
                    ex_mem_load      <= id_ex_load;
                    ex_mem_store     <= id_ex_store;
                    ex_mem_res       <= ex_res;
                    ex_mem_sdata     <= ex_b;
                    // load data at end of memory stage
                    mem_wb_wen       <= ex_mem_wen;
                    mem_wb_dest      <= ex_mem_dest;
                    mem_wb_val       <= ex_mem_load ? i_bus_rdata : ex_mem_res;
                    o_bus_addr       <= pc_next;
                    o_bus_data_phase <= 1'b0;
                    o_bus_rd         <= 1'b1;
                    o_bus_wr         <= 1'b0;
                    o_wb_en          <= mem_wb_wen && (mem_wb_dest != `GPR_ZERO);
                    o_wb_reg         <= mem_wb_dest;
                    o_wb_data        <= mem_wb_val;
                end
                default: begin
                    state_reg <= ST_INSN;
                end
            endcase
        end
    end

    // register file write
    // storage has no reset; register zero is masked on read instead
    always @(posedge i_clk_sys) begin
        if (!i_rst && i_ce && state_reg == ST_DATA && mem_wb_wen
            && mem_wb_dest != `GPR_ZERO) begin
            gpr[mem_wb_dest] <= mem_wb_val;
        end
    end

endmodule // pipe_core

`default_nettype wire

/* File: testbench/pipe_core_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module pipe_core_monitor (
    // clock and control
    input wire logic        i_clk_sys,
    input wire logic        i_rst,
    input wire logic        i_ce,
    // cache bus
    input wire logic [31:0] o_bus_addr,
    input wire logic        o_bus_data_phase,
    input wire logic        o_bus_rd,
    input wire logic        o_bus_wr,
    input wire logic [31:0] i_bus_rdata,
    // writeback view
    input wire logic        o_wb_en,
    input wire logic [4:0]  o_wb_reg,
    input wire logic [31:0] o_wb_data
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    AST_PHASE_ALT: assert property (
        i_ce |=> o_bus_data_phase != $past(o_bus_data_phase)) else $error("phase order");
    AST_FREEZE: assert property (
        !i_ce |=> $stable(o_bus_addr) && $stable(o_bus_data_phase) && $stable(o_wb_data))
        else $error("moved while frozen");
    AST_IFETCH: assert property (!o_bus_data_phase |-> o_bus_rd && !o_bus_wr)
        else $error("bad fetch phase");
    AST_WR_DATA: assert property (o_bus_wr |-> o_bus_data_phase && !o_bus_rd)
        else $error("bad store phase");
    AST_WB_HOLD: assert property (
        i_ce && !o_bus_data_phase |=> $stable({o_wb_en, o_wb_reg, o_wb_data}))
        else $error("writeback mid cycle");
    AST_WB_NOT_R0: assert property (o_wb_en |-> o_wb_reg != 5'h00)
        else $error("write to zero reg");
    AST_RESET_FETCH: assert property (
        $past(i_rst) |-> o_bus_addr == 32'h0 && !o_bus_data_phase && !o_wb_en)
        else $error("bad reset state");
    // load data reaches the writeback view one processor cycle after its data phase
    logic        ld_seen;
    logic [31:0] ld_word;
    always @(posedge i_clk_sys) begin
        if (i_rst) begin
            ld_seen <= 1'b0;
        end else if (i_ce && o_bus_data_phase) begin
            ld_seen <= o_bus_rd;
            ld_word <= i_bus_rdata;
        end
    end
    AST_LOAD_WB: assert property (
        i_ce && o_bus_data_phase && ld_seen |=> !o_wb_en || o_wb_data == $past(ld_word))
        else $error("load data lost");
endmodule // pipe_core_monitor
bind pipe_core pipe_core_monitor u_mon (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce),
    .o_bus_addr(o_bus_addr), .o_bus_data_phase(o_bus_data_phase), .o_bus_rd(o_bus_rd),
    .o_bus_wr(o_bus_wr), .i_bus_rdata(i_bus_rdata), .o_wb_en(o_wb_en),
    .o_wb_reg(o_wb_reg), .o_wb_data(o_wb_data));
`default_nettype wire

/* File: testbench/cache_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cache_model (
    // bus from the core
    input wire logic        i_clk_sys,
    input wire logic        i_ce,
    input wire logic [31:0] i_addr,
    input wire logic        i_data_phase,
    input wire logic        i_rd,
    input wire logic        i_wr,
    input wire logic [31:0] i_wdata,
    // zero-wait answer
    output var logic [31:0] o_rdata
);
    logic [31:0] imem [0:63];
    logic [31:0] dmem [0:15];
    logic [31:0] last = 32'h0;
    always_comb
        if (!i_data_phase) o_rdata = imem[i_addr[7:2]];
        else if (i_rd) o_rdata = dmem[i_addr[5:2]];
        else o_rdata = ~last;
    // store in one phase; idle bus toggles so stale data is never seen
    always @(posedge i_clk_sys) begin
        if (i_ce && i_data_phase && i_wr) dmem[i_addr[5:2]] <= i_wdata;
        if (i_ce) last <= o_rdata;
    end
endmodule // cache_model
`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pipe_defs.vh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
    logic        clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, bus_dp, bus_rd, bus_wr, wb_en;
    logic [31:0] bus_addr, bus_wdata, bus_rdata, wb_data, prog[$];
    logic [4:0]  wb_reg;
    logic [44:0] got[$], exp[$];
    int          n_errors = 0, n_compared = 0, stamp = 0, stall = 0, tick = 0;
    pipe_core DUT (.i_clk_sys(clk_sys), .i_rst(rst), .i_ce(ce), .o_bus_addr(bus_addr),
        .o_bus_data_phase(bus_dp), .o_bus_rd(bus_rd), .o_bus_wr(bus_wr),
        .o_bus_wdata(bus_wdata), .i_bus_rdata(bus_rdata), .o_wb_en(wb_en),
        .o_wb_reg(wb_reg), .o_wb_data(wb_data));
    cache_model mdl (.i_clk_sys(clk_sys), .i_ce(ce), .i_addr(bus_addr), .i_data_phase(bus_dp),
        .i_rd(bus_rd), .i_wr(bus_wr), .i_wdata(bus_wdata), .o_rdata(bus_rdata));
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    // stall mode models a cache miss every third bus cycle
    always @(negedge clk_sys) begin
        tick++;
        ce <= !(stall != 0 && tick % 3 == 0);
    end
    // log each write once, stamped with the processor cycle
    always @(posedge clk_sys) if (!rst && ce) begin
        if (!bus_dp && wb_en) got.push_back({stamp[7:0], wb_reg, wb_data});
        if (bus_dp) stamp++;
    end
    function automatic logic [31:0] ins(input logic [5:0] op, input logic [4:0] rs, rt,
            input logic [15:0] imm);
        return {op, rs, rt, imm};
    endfunction
    task automatic run();
        for (int k = 0; k < 64; k++) mdl.imem[k] = k < prog.size() ? prog[k] : `NOP_WORD;
        got = {};
        @(negedge clk_sys) rst = 1'b1;
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        repeat (80) @(negedge clk_sys);
        `CHK("wb count", exp.size(), got.size())
        for (int k = 0; k < exp.size() && k < got.size(); k++)
            `CHK("wb entry", exp[k], {got[k][44:37] - got[0][44:37], got[k][36:0]})
    endtask
    task automatic s_alu(input int st);
        stall = st;
        prog = '{ins(`OP_ADDI, 0, 1, 16'h5), ins(`OP_ADDI, 1, 2, 16'h3),
            ins(`OP_ALU, 2, 1, {5'h03, 5'h0, `FN_SUB}), ins(`OP_ALU, 2, 3, {5'h04, 5'h0, `FN_AND}),
            ins(`OP_ALU, 2, 3, {5'h1F, 5'h0, `FN_OR}), ins(`OP_ALU, 1, 1, {5'h00, 5'h0, `FN_ADD}),
            ins(`OP_ALU, 1, 1, {5'h05, 5'h0, `FN_ADD}), ins(`OP_ALU, 0, 1, {5'h06, 5'h0, `FN_SUB})};
        exp = '{{8'h0, 5'h1, 32'h5}, {8'h1, 5'h2, 32'h8}, {8'h2, 5'h3, 32'h3},
            {8'h3, 5'h4, 32'h0}, {8'h4, 5'h1F, 32'hB}, {8'h6, 5'h5, 32'hA},
            {8'h7, 5'h6, 32'hFFFFFFFB}};
        run();
        stall = 0;
    endtask
    task automatic s_mem();
        prog = '{ins(`OP_ADDI, 0, 1, 16'h7), ins(`OP_ADDI, 0, 2, 16'h10),
            ins(`OP_STORE, 0, 1, 16'h8), ins(`OP_LOAD, 0, 2, 16'h8),
            ins(`OP_ADDI, 2, 3, 16'h1), ins(`OP_ADDI, 2, 4, 16'h1)};
        exp = '{{8'h0, 5'h1, 32'h7}, {8'h1, 5'h2, 32'h10}, {8'h3, 5'h2, 32'h7},
            {8'h4, 5'h3, 32'h11}, {8'h5, 5'h4, 32'h8}};
        // load delay; slot sees old value
        run();
        `CHK("stored word", 32'h7, mdl.dmem[2])
    endtask
    task automatic s_br();
        prog = '{ins(`OP_ADDI, 0, 1, 16'h1), ins(`OP_ADDI, 0, 2, 16'hFFFF), `NOP_WORD,
            ins(`OP_BEQ, 1, 1, 16'h2), ins(`OP_ADDI, 0, 3, 16'h3), ins(`OP_ADDI, 0, 4, 16'h4),
            ins(`OP_BNE, 1, 1, 16'h5), ins(`OP_ADDI, 0, 5, 16'h5),
            ins(`OP_BLTZ, 2, 0, 16'h2), ins(`OP_ADDI, 0, 6, 16'h6), ins(`OP_ADDI, 0, 7, 16'h7),
            ins(`OP_BGEZ, 2, 0, 16'h2), ins(`OP_ADDI, 0, 8, 16'h8), ins(`OP_ADDI, 0, 9, 16'h9)};
        exp = '{{8'h0, 5'h1, 32'h1}, {8'h1, 5'h2, 32'hFFFFFFFF}, {8'h4, 5'h3, 32'h3},
            {8'h6, 5'h5, 32'h5}, {8'h8, 5'h6, 32'h6}, {8'hA, 5'h8, 32'h8}, {8'hB, 5'h9, 32'h9}};
        run();
    endtask
    task results;
        if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        s_alu(0);
        s_alu(1);
        s_mem();
        s_br();
        results();
    end
endmodule // tb
`default_nettype wire
